// file: hw/rtcc_pkg.sv
// Operation
// - interrupts go out as controller request lines
// - deep wake only with slow clock source
// - time register holds BCD digits by field
// - bit 22 marks afternoon
// - time clears on reset unless bypass set
// - date loads 2101 on reset unless bypass
// - calendar writes only unlocked and in init
// - date register holds BCD fields by layout
// - bit 23 enables calibration output
// - select field routes alarm flag to pin
// - bit 20 inverts alarm pin
// - bit 19 picks 512 Hz or 1 Hz
// - minus one hour at next second, nonzero
// - plus one hour at next second
// - bits 15 and 12 gate stamp and alarm requests
// - bits 11 and 8 enable stamp and alarm
// - bit 6 picks 12 hour, init only
// - bit 5 reads live calendar not shadow
// - bit 4 reference detect, init only
// - bit 3 picks stamp input edge
// - alarm pin follows alarm flag when selected, xor bit 20
// - stamp captures calendar on first event only
package rtcc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0]  TIME_OFS    = 8'h00;
    localparam logic [7:0]  DATE_OFS    = 8'h04;
    localparam logic [7:0]  CTRL_OFS    = 8'h08;
    localparam logic [7:0]  STAT_OFS    = 8'h0c;
    localparam logic [7:0]  STAMP_T_OFS = 8'h10;
    localparam logic [7:0]  STAMP_D_OFS = 8'h14;
    localparam logic [7:0]  ALARM_OFS   = 8'h18;
    localparam logic [7:0]  KEY_OFS     = 8'h1c;

    localparam logic [31:0] TIME_RST    = 32'h0000_0000;
    localparam logic [31:0] DATE_RST    = 32'h0000_2101;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] TIME_MASK   = 32'h007f_7f7f;
    localparam logic [31:0] DATE_MASK   = 32'h00ff_ff3f;
    localparam logic [31:0] CTRL_MASK   = 32'h00ff_9978;
    localparam logic [31:0] KEY_OPEN    = 32'h0000_00ca;

    // control bit positions
    localparam int CAL_OUT_EN    = 23;
    localparam int PIN_SEL_HI    = 22;
    localparam int PIN_SEL_LO    = 21;
    localparam int PIN_INV       = 20;
    localparam int CAL_RATE      = 19;
    localparam int HOUR_MINUS    = 17;
    localparam int HOUR_PLUS     = 16;
    localparam int STAMP_IRQ_EN  = 15;
    localparam int ALARM_IRQ_EN  = 12;
    localparam int STAMP_FN_EN   = 11;
    localparam int ALARM_FN_EN   = 8;
    localparam int TWELVE_HOUR   = 6;
    localparam int SHADOW_BYP    = 5;
    localparam int REF_DET_EN    = 4;
    localparam int STAMP_EDGE    = 3;
    // status bit positions
    localparam int ST_INTR1      = 14;
    localparam int ST_INTR0      = 13;
    localparam int ST_STAMP      = 11;
    localparam int ST_ALARM      = 8;
    localparam int ST_INIT_REQ   = 7;
    localparam int ST_INIT_FLAG  = 6;
    localparam logic [31:0] STAT_W0C = 32'h0000_6900;

    // calibration output dividers on the tick clock
    localparam int CAL_FAST_DIV  = 64;
    localparam int TICK_HZ       = 32768;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } rtcc_bus_type;

    typedef struct packed {
        logic [31:0] time_live;
        logic [31:0] date_live;
        logic [31:0] time_shadow;
        logic [31:0] date_shadow;
        logic [31:0] ctrl;
        logic [31:0] stat;
        logic [31:0] stamp_time;
        logic [31:0] stamp_date;
        logic [31:0] alarm_time;
        logic        unlocked;
        logic        adj_minus;
        logic        adj_plus;
        logic        stamp_prev;
        logic [15:0] cal_cnt;
        logic        cal_out;
        logic        alarm_pin;
        logic        alarm_irq;
        logic        stamp_irq;
        logic        intr_irq;
        logic        wake;
        logic [31:0] rdata;
    } rtcc_state_type;

endpackage

// file: hw/rtcc_regs.sv
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module rtcc_regs (
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    input  wire logic                   bkp_nrst_i,
    input  wire rtcc_pkg::rtcc_bus_type bus_i,
    input  wire logic                   sec_tick_i,
    input  wire logic                   cal_tick_i,
    input  wire logic                   stamp_pin_i,
    input  wire logic                   intr0_evt_i,
    input  wire logic                   intr1_evt_i,
    input  wire logic                   slow_clk_src_i,
    input  wire logic                   deep_sleep_i,
    output logic [31:0]                 rdata_o,
    output logic                        cal_out_o,
    output logic                        alarm_pin_o,
    output logic                        alarm_irq_o,
    output logic                        stamp_irq_o,
    output logic                        intr_irq_o,
    output logic                        wake_o
);
    import rtcc_pkg::*;

    rtcc_state_type r;
    rtcc_state_type next_r;
    logic           sys_rst_pend;

    ////////////////////////////////////////////////////////////////////////////////
    // bcd helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] bcd_dec(input logic [7:0] v);
        bcd_dec = (v[3:0] == 4'h0) ? {v[7:4] - 4'h1, 4'h9} : {v[7:4], v[3:0] - 4'h1};
    endfunction

    // last day of month, BCD month and year
    function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = (((y[7:4] % 4'h2) == 4'h0) && (y[3:0] % 4'h4 == 4'h0))
            || ((y[7:4] % 4'h2 == 4'h1) && (y[3:0] % 4'h4 == 4'h2));
        case (m)
            8'h02:   month_end = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
            default: month_end = 8'h31;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hr;
        logic [7:0] day;
        logic [7:0] mon;
        logic [7:0] yr;
        logic [2:0] wd;
        logic       pm;
        logic       twelve;
        logic       init;
        logic       day_over;
        logic       stamp_edge;
        next_r = r;
        init   = r.stat[ST_INIT_FLAG];
        twelve = r.ctrl[TWELVE_HOUR];
        sec = {1'b0, r.time_live[6:0]};
        min = {1'b0, r.time_live[14:8]};
        hr  = {2'b00, r.time_live[21:16]};
        pm  = r.time_live[22];
        yr  = r.date_live[23:16];
        wd  = r.date_live[15:13];
        mon = {3'b000, r.date_live[12:8]};
        day = {2'b00, r.date_live[5:0]};
        day_over = 1'b0;
        stamp_edge = 1'b0;

        // calendar advance, stopped while in init state
        if (sec_tick_i && !init) begin
            if (sec == 8'h59) begin
                sec = 8'h00;
                if (min == 8'h59) begin
                    min = 8'h00;
                    if (twelve) begin
                        if (hr == 8'h11) begin
                            hr = 8'h12;
                            pm = ~pm;
                            day_over = ~pm;
                        end else if (hr == 8'h12) begin
                            hr = 8'h01;
                        end else begin
                            hr = bcd_inc(hr);
                        end
                    end else if (hr == 8'h23) begin
                        hr = 8'h00;
                        day_over = 1'b1;
                    end else begin
                        hr = bcd_inc(hr);
                    end
                end else begin
                    min = bcd_inc(min);
                end
            end else begin
                sec = bcd_inc(sec);
            end
            // hour adjust at seconds change
            if (r.adj_plus) begin
                if (!twelve && hr == 8'h23) hr = 8'h00;
                else if (twelve && hr == 8'h12) hr = 8'h01;
                else if (twelve && hr == 8'h11) begin
                    hr = 8'h12;
                    pm = ~pm;
                end else hr = bcd_inc(hr);
                next_r.adj_plus = 1'b0;
            end
            if (r.adj_minus) begin
                if (hr != 8'h00) begin
                    if (twelve && hr == 8'h01) hr = 8'h12;
                    else if (twelve && hr == 8'h12) begin
                        hr = 8'h11;
                        pm = ~pm;
                    end else hr = bcd_dec(hr);
                end
                next_r.adj_minus = 1'b0;
            end
            if (day_over) begin
                wd = (wd == 3'h7) ? 3'h1 : wd + 3'h1;
                if (day == month_end(mon, yr)) begin
                    day = 8'h01;
                    if (mon == 8'h12) begin
                        mon = 8'h01;
                        yr  = (yr == 8'h99) ? 8'h00 : bcd_inc(yr);
                    end else begin
                        mon = bcd_inc(mon);
                    end
                end else begin
                    day = bcd_inc(day);
                end
            end
            next_r.time_live = {9'h000, pm, hr[5:0], 1'b0, min[6:0], 1'b0, sec[6:0]};
            next_r.date_live = {8'h00, yr, wd, mon[4:0], 2'b00, day[5:0]};
            next_r.time_shadow = next_r.time_live;
            next_r.date_shadow = next_r.date_live;
        end

        // alarm compare on time fields
        if (r.ctrl[ALARM_FN_EN] && sec_tick_i && !init
            && ((next_r.time_live & TIME_MASK) == (r.alarm_time & TIME_MASK)))
            next_r.stat[ST_ALARM] = 1'b1;

        // time-stamp edge detect and first-event capture
        stamp_edge = r.ctrl[STAMP_EDGE] ? (r.stamp_prev && !stamp_pin_i)
                                         : (!r.stamp_prev && stamp_pin_i);
        next_r.stamp_prev = stamp_pin_i;
        if (intr0_evt_i) next_r.stat[ST_INTR0] = 1'b1;
        if (intr1_evt_i) next_r.stat[ST_INTR1] = 1'b1;

        // register writes; hardware sets below take priority
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                TIME_OFS: if (r.unlocked && init) begin
                    next_r.time_live = bus_i.wdata & TIME_MASK;
                    next_r.time_shadow = bus_i.wdata & TIME_MASK;
                end
                DATE_OFS: if (r.unlocked && init) begin
                    next_r.date_live = bus_i.wdata & DATE_MASK;
                    next_r.date_shadow = bus_i.wdata & DATE_MASK;
                end
                CTRL_OFS: if (r.unlocked) begin
                    next_r.ctrl = bus_i.wdata & CTRL_MASK;
                    next_r.ctrl[HOUR_PLUS] = 1'b0;
                    next_r.ctrl[HOUR_MINUS] = 1'b0;
                    if (bus_i.wdata[HOUR_PLUS]) next_r.adj_plus = 1'b1;
                    if (bus_i.wdata[HOUR_MINUS]) next_r.adj_minus = 1'b1;
                    if (!init) begin
                        next_r.ctrl[TWELVE_HOUR] = r.ctrl[TWELVE_HOUR];
                        next_r.ctrl[REF_DET_EN] = r.ctrl[REF_DET_EN];
                    end
                end
                STAT_OFS: begin
                    next_r.stat = r.stat & (bus_i.wdata | ~STAT_W0C);
                    if (r.unlocked) begin
                        next_r.stat[ST_INIT_REQ] = bus_i.wdata[ST_INIT_REQ];
                    end
                end
                ALARM_OFS: if (r.unlocked) next_r.alarm_time = bus_i.wdata & TIME_MASK;
                KEY_OFS: next_r.unlocked = (bus_i.wdata == KEY_OPEN);
                default: ;
            endcase
        end
        next_r.stat[ST_INIT_FLAG] = next_r.stat[ST_INIT_REQ];
        if (r.ctrl[ALARM_FN_EN] && sec_tick_i && !init
            && ((next_r.time_live & TIME_MASK) == (r.alarm_time & TIME_MASK)))
            next_r.stat[ST_ALARM] = 1'b1;
        if (intr0_evt_i) next_r.stat[ST_INTR0] = 1'b1;
        if (intr1_evt_i) next_r.stat[ST_INTR1] = 1'b1;
        if (r.ctrl[STAMP_FN_EN] && stamp_edge) begin
            if (!r.stat[ST_STAMP]) begin
                next_r.stamp_time = r.time_live;
                next_r.stamp_date = r.date_live;
            end
            next_r.stat[ST_STAMP] = 1'b1;
        end

        // calibration clock from the prescaler tick
        if (cal_tick_i) begin
            next_r.cal_cnt = (r.cal_cnt == 16'(TICK_HZ - 1)) ? 16'h0000 : r.cal_cnt + 16'h0001;
        end
        next_r.cal_out = r.ctrl[CAL_OUT_EN] && (r.ctrl[CAL_RATE]
                         ? (r.cal_cnt < 16'(TICK_HZ / 2))
                         : (r.cal_cnt[5:0] < 6'(CAL_FAST_DIV / 2)));

        // alarm pin, follows flag when selected, xor the invert bit
        next_r.alarm_pin = (r.ctrl[PIN_SEL_HI:PIN_SEL_LO] == 2'b01)
                           && (next_r.stat[ST_ALARM] ^ r.ctrl[PIN_INV]);

        // request lines to the external interrupt controller
        next_r.alarm_irq = next_r.stat[ST_ALARM] && r.ctrl[ALARM_IRQ_EN];
        next_r.stamp_irq = next_r.stat[ST_STAMP] && r.ctrl[STAMP_IRQ_EN];
        next_r.intr_irq  = next_r.stat[ST_INTR0] || next_r.stat[ST_INTR1];
        next_r.wake = (next_r.alarm_irq || next_r.stamp_irq || next_r.intr_irq)
                      && (slow_clk_src_i || !deep_sleep_i);

        // read data, one cycle after the strobe
        next_r.rdata = 32'h0000_0000;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                TIME_OFS:    next_r.rdata = r.ctrl[SHADOW_BYP] ? r.time_live : r.time_shadow;
                DATE_OFS:    next_r.rdata = r.ctrl[SHADOW_BYP] ? r.date_live : r.date_shadow;
                CTRL_OFS:    next_r.rdata = r.ctrl;
                STAT_OFS:    next_r.rdata = r.stat;
                STAMP_T_OFS: next_r.rdata = r.stamp_time;
                STAMP_D_OFS: next_r.rdata = r.stamp_date;
                ALARM_OFS:   next_r.rdata = r.alarm_time;
                default:     next_r.rdata = 32'h0000_0000;
            endcase
        end

        // system reset: calendar only reloads without bypass
        if (sys_rst_pend) begin
            next_r.stat[ST_INIT_REQ] = 1'b0;
            next_r.stat[ST_INIT_FLAG] = 1'b0;
            next_r.unlocked = 1'b0;
            if (!r.ctrl[SHADOW_BYP]) begin
                next_r.time_live = TIME_RST;
                next_r.time_shadow = TIME_RST;
                next_r.date_live = DATE_RST;
                next_r.date_shadow = DATE_RST;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // system reset seen as a pending action, held through reset and until the first edge after release
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) sys_rst_pend <= 1'b1;
        else         sys_rst_pend <= 1'b0;
    end

    // state register, backup-domain reset clears all but the date, which loads DATE_RST
    always_ff @(posedge clk_i or negedge bkp_nrst_i) begin
        if (!bkp_nrst_i) begin
            r <= '0;
            r.date_live <= DATE_RST;
            r.date_shadow <= DATE_RST;
        end else begin
            r <= next_r;
        end
    end

    assign rdata_o     = r.rdata;
    assign cal_out_o   = r.cal_out;
    assign alarm_pin_o = r.alarm_pin;
    assign alarm_irq_o = r.alarm_irq;
    assign stamp_irq_o = r.stamp_irq;
    assign intr_irq_o  = r.intr_irq;
    assign wake_o      = r.wake;
endmodule

// file: dv/rtcc_props.sv
`timescale 1ns/1ps
module rtcc_props (
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    input  wire logic                   bkp_nrst_i,
    input  wire rtcc_pkg::rtcc_bus_type bus_i,
    input  wire logic                   intr0_evt_i,
    input  wire logic                   intr1_evt_i,
    input  wire logic                   slow_clk_src_i,
    input  wire logic                   deep_sleep_i,
    input  wire logic [31:0]            rdata_o,
    input  wire logic                   alarm_irq_o,
    input  wire logic                   stamp_irq_o,
    input  wire logic                   intr_irq_o,
    input  wire logic                   wake_o
);
    import rtcc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i || !bkp_nrst_i);

    ////////////////////////////////////////////////////////////////////////////////
    // read request to one register
    sequence rd_at(logic [7:0] a);
        bus_i.rd && bus_i.addr == a;
    endsequence
    sequence any_irq;
        alarm_irq_o || stamp_irq_o || intr_irq_o;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!bus_i.rd |=> rdata_o == 32'h0)
        else $error("read data not zero outside a read answer");
    time_fields_a: assert property (rd_at(TIME_OFS) |=> (rdata_o & ~TIME_MASK) == 32'h0)
        else $error("time read shows reserved bits");
    date_fields_a: assert property (rd_at(DATE_OFS) |=> (rdata_o & ~DATE_MASK) == 32'h0)
        else $error("date read shows reserved bits");
    ctrl_fields_a: assert property (rd_at(CTRL_OFS) |=> rdata_o[17:16] == 2'h0)
        else $error("hour adjust bits read back nonzero");
    unmapped_read_a: assert property (bus_i.rd && bus_i.addr > 8'h1c |=> rdata_o == 32'h0)
        else $error("unmapped read returned data");
    wake_gate_a: assert property (wake_o |-> $past(slow_clk_src_i) || !$past(deep_sleep_i))
        else $error("deep sleep wake without slow clock source");
    wake_cause_a: assert property (wake_o |-> any_irq)
        else $error("wake without an interrupt request");
    tamper_route_a: assert property ($rose(intr_irq_o) |-> $past(intr0_evt_i || intr1_evt_i)
        || $past(intr0_evt_i || intr1_evt_i, 2))
        else $error("tamper request without tamper event");
endmodule
bind rtcc_regs rtcc_props rtcc_props_inst (.clk_i, .nrst_i, .bkp_nrst_i, .bus_i, .intr0_evt_i,
    .intr1_evt_i, .slow_clk_src_i, .deep_sleep_i, .rdata_o, .alarm_irq_o, .stamp_irq_o,
    .intr_irq_o, .wake_o);

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import rtcc_pkg::*;
    logic         clk_i = 1'b0;
    logic         nrst_i, bkp_nrst_i, sec_tick_i, cal_tick_i, stamp_pin_i;
    logic         intr0_evt_i, intr1_evt_i, slow_clk_src_i, deep_sleep_i, prev;
    rtcc_bus_type bus_i;
    logic [31:0]  rdata_o, rd_val;
    logic         cal_out_o, alarm_pin_o, alarm_irq_o, stamp_irq_o, intr_irq_o, wake_o;
    logic [5:0]   outs;
    int           n_errors, checks_done, rises;

    assign outs = {wake_o, intr_irq_o, stamp_irq_o, alarm_irq_o, alarm_pin_o, cal_out_o};
    always #5 clk_i = ~clk_i;

    rtcc_regs rtcc_regs_inst (.clk_i, .nrst_i, .bkp_nrst_i, .bus_i, .sec_tick_i, .cal_tick_i,
        .stamp_pin_i, .intr0_evt_i, .intr1_evt_i, .slow_clk_src_i, .deep_sleep_i, .rdata_o,
        .cal_out_o, .alarm_pin_o, .alarm_irq_o, .stamp_irq_o, .intr_irq_o, .wake_o);

    ////////////////////////////////////////////////////////////////////////////////
    // compare and bus tasks
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
    endtask
    task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
        #1 rd_val = rdata_o;
        chk(name, exp, rd_val);
    endtask
    // one calendar second
    task tick;
        @(posedge clk_i);
        sec_tick_i <= 1'b1;
        @(posedge clk_i);
        sec_tick_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    // registered outputs need a few edges to follow
    task settle;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task pulse_reset;
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {nrst_i, bkp_nrst_i, sec_tick_i, cal_tick_i, stamp_pin_i} = 5'h0;
        {intr0_evt_i, intr1_evt_i, slow_clk_src_i, deep_sleep_i} = 4'h3;
        bus_i = '0;
        n_errors = 0;
        checks_done = 0;
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        bkp_nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rchk("time", TIME_OFS, TIME_RST);
        rchk("date", DATE_OFS, DATE_RST);
        rchk("ctrl", CTRL_OFS, CTRL_RST);
        rchk("unmapped", 8'h20, 32'h0);
        wr(TIME_OFS, 32'h0000_0101);
        rchk("locked time", TIME_OFS, 32'h0);
        wr(KEY_OFS, KEY_OPEN);
        wr(CTRL_OFS, 32'h0000_0070);
        rchk("init only bits", CTRL_OFS, 32'h0000_0020);
        wr(TIME_OFS, 32'h0000_0101);
        rchk("time outside init", TIME_OFS, 32'h0);
        $display("protection test done");
        wr(STAT_OFS, 32'h0000_0080);
        wr(CTRL_OFS, 32'h0000_0070);
        rchk("ctrl in init", CTRL_OFS, 32'h0000_0070);
        wr(TIME_OFS, 32'h0011_5959);
        wr(STAT_OFS, 32'h0);
        tick;
        rchk("noon", TIME_OFS, 32'h0052_0000);
        wr(STAT_OFS, 32'h0000_0080);
        wr(CTRL_OFS, 32'h0000_0030);
        wr(TIME_OFS, 32'h0023_5958);
        wr(DATE_OFS, 32'h0099_d231);
        wr(STAT_OFS, 32'h0);
        tick;
        rchk("time step", TIME_OFS, 32'h0023_5959);
        tick;
        rchk("midnight", TIME_OFS, 32'h0);
        rchk("new year", DATE_OFS, 32'h0000_e101);
        $display("calendar test done");
        wr(CTRL_OFS, 32'h0002_0030);
        tick;
        rchk("minus at zero", TIME_OFS, 32'h0000_0001);
        wr(CTRL_OFS, 32'h0001_0030);
        tick;
        rchk("plus hour", TIME_OFS, 32'h0001_0002);
        wr(CTRL_OFS, 32'h0002_0030);
        tick;
        rchk("minus hour", TIME_OFS, 32'h0000_0003);
        rchk("adjust reads", CTRL_OFS, 32'h0000_0030);
        pulse_reset;
        rchk("kept time", TIME_OFS, 32'h0000_0003);
        rchk("kept date", DATE_OFS, 32'h0000_e101);
        wr(KEY_OFS, KEY_OPEN);
        wr(CTRL_OFS, 32'h0000_0010);
        pulse_reset;
        rchk("cleared time", TIME_OFS, TIME_RST);
        rchk("cleared date", DATE_OFS, DATE_RST);
        rchk("ctrl kept", CTRL_OFS, 32'h0000_0010);
        $display("adjust and reset test done");
        wr(KEY_OFS, KEY_OPEN);
        wr(ALARM_OFS, 32'h0000_0001);
        wr(CTRL_OFS, 32'h0020_1030);
        wr(CTRL_OFS, 32'h0020_1130);
        tick;
        settle;
        chk("alarm", 6'b100110, outs);
        @(posedge clk_i) slow_clk_src_i <= 1'b0;
        settle;
        chk("fast source", 6'b000110, outs);
        @(posedge clk_i) deep_sleep_i <= 1'b0;
        settle;
        chk("sleep wake", 6'b100110, outs);
        wr(CTRL_OFS, 32'h0030_1130);
        settle;
        chk("inverted", 6'b100100, outs);
        wr(STAT_OFS, 32'h0);
        settle;
        chk("flag cleared", 6'b000010, outs);
        wr(CTRL_OFS, 32'h0010_0030);
        settle;
        chk("pin off", 6'b000000, outs);
        $display("alarm test done");
        wr(CTRL_OFS, 32'h0000_0838);
        stamp_pin_i <= 1'b1;
        settle;
        @(posedge clk_i) stamp_pin_i <= 1'b0;
        settle;
        chk("stamp gated", 6'b000000, outs);
        wr(CTRL_OFS, 32'h0000_8838);
        settle;
        chk("stamp irq", 6'b101000, outs);
        tick;
        stamp_pin_i <= 1'b1;
        settle;
        @(posedge clk_i) stamp_pin_i <= 1'b0;
        settle;
        rchk("stamp time", STAMP_T_OFS, 32'h0000_0001);
        rchk("stamp date", STAMP_D_OFS, DATE_RST);
        wr(STAT_OFS, 32'h0);
        @(posedge clk_i);
        intr0_evt_i <= 1'b1;
        @(posedge clk_i);
        intr0_evt_i <= 1'b0;
        settle;
        chk("tamper", 6'b110000, outs);
        // rising edge mode captures the later time
        wr(CTRL_OFS, 32'h0000_0830);
        stamp_pin_i <= 1'b1;
        settle;
        rchk("stamp rising", STAMP_T_OFS, 32'h0000_0002);
        $display("stamp and tamper test done");
        wr(STAT_OFS, 32'h0);
        wr(CTRL_OFS, 32'h0080_0030);
        rises = 0;
        prev = cal_out_o;
        // count output rises over ten fast periods
        repeat (640) begin
            @(posedge clk_i);
            cal_tick_i <= 1'b1;
            @(posedge clk_i);
            cal_tick_i <= 1'b0;
            #1 if (cal_out_o && !prev) rises++;
            prev = cal_out_o;
        end
        chk("cal rate", 32'h1, {31'h0, rises >= 9 && rises <= 11});
        wr(CTRL_OFS, 32'h0088_0030);
        rises = 0;
        prev = cal_out_o;
        // tick on every edge: one slow period is one full counter wrap
        @(posedge clk_i) cal_tick_i <= 1'b1;
        repeat (32768) begin
            @(posedge clk_i);
            #1 if (cal_out_o && !prev) rises++;
            prev = cal_out_o;
        end
        @(posedge clk_i) cal_tick_i <= 1'b0;
        chk("cal slow rate", 32'h1, rises);
        wr(CTRL_OFS, 32'h0000_0030);
        settle;
        chk("cal off", 6'b000000, outs);
        $display("calibration test done");
        results;
    end

    // watchdog well beyond the expected run length
    initial begin
        #600us;
        n_errors++;
        $display("watchdog expired");
        results;
    end
endmodule
